// *** design/spllk_pkg.sv ***
// constants and types for the loop divider and lock detector block
package spllk_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] ADDR_PWR = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
   // power_config_register layout
   localparam int PWR_PD_BIT = 7;
   localparam logic [31:0] PWR_RESET = 32'h0000_6DF0;
   localparam logic [31:0] PWR_MASK = 32'h0000_7FFF;
   // loop_divider_control layout
   localparam int DIV_FEEDBACK_DIV_SELECT_LSB = 0;
   localparam int DIV_PSEL_LSB = 5;
   localparam int DIV_BYPASS_BIT = 7;
   localparam logic [7:0] DIV_RESET = 8'h00;
   // status and interrupt bit positions
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_PD_BIT = 1;
   localparam int IRQ_LOCK_GAIN_BIT = 0;
   localparam int IRQ_LOCK_LOSS_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // lock detector: matches needed before the count exceeds eight
   localparam logic [3:0] LOCK_MATCH_LAST = 4'h8;
   localparam logic [3:0] LOCK_MATCH_RESET = 4'h0;
   // lock criterion as a count of system clock cycles after the feedback edge
   localparam logic [7:0] LOCK_CRIT_CYC = 8'h02;
   localparam logic [7:0] SINCE_FB_MAX = 8'hFF;
   localparam logic [4:0] PCNT_RESET = 5'h00;
   localparam logic [4:0] FCNT_RESET = 5'h00;

   typedef struct packed {
      logic bypass;
      logic [1:0] psel;
      logic [4:0] feedback_div_select;
   } spllk_div_type;
endpackage

// *** design/spllk_top.sv ***
// loop post and feedback dividers, lock detector, power-down and register slave
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module spllk_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ref_clk_in,
   input wire logic osc_clk_in,
   output logic osc_run,
   output logic main_clk_out,
   output logic fb_clk_out,
   output logic lock,
   output logic irq
);
   // post divider P from the two-bit code
   function automatic logic [4:0] p_value(input logic [1:0] code);
      logic [4:0] v;
      v = 5'h01 << code;
      return v;
   endfunction

   logic [31:0] pwr_q, pwr_d;
   spllk_pkg::spllk_div_type div_q, div_d;
   logic [1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
   logic ack_q;
   logic [31:0] dat_q;
   logic irq_q;
   logic osc_prev_q, ref_prev_q;
   logic [4:0] pcnt_q, pcnt_d, fcnt_q, fcnt_d;
   logic post_q, post_d, main_q, main_d, fb_q, fb_d;
   logic [7:0] since_fb_q, since_fb_d;
   logic [3:0] match_cnt_q, match_cnt_d;
   logic lock_q, lock_d;
   logic run_q;

   // bus decode
   wire logic req = wb_cyc_i & wb_stb_i;
   wire logic wr_now = ack_q & req & wb_we_i;
   wire logic hit_pwr = wb_adr_i == spllk_pkg::ADDR_PWR;
   wire logic hit_div = wb_adr_i == spllk_pkg::ADDR_DIV;
   wire logic hit_clr = wb_adr_i == spllk_pkg::ADDR_IRQ_CLR;
   wire logic hit_en = wb_adr_i == spllk_pkg::ADDR_IRQ_EN;
   wire logic [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] wmask = lane_mask;
   wire logic [31:0] div_word = {24'h000000, div_q};
   wire logic [31:0] stat_word = {30'h0, pwr_q[spllk_pkg::PWR_PD_BIT], lock_q};
   wire logic [31:0] rdata =
      hit_pwr ? pwr_q :
      hit_div ? div_word :
      (wb_adr_i == spllk_pkg::ADDR_STAT) ? stat_word :
      (wb_adr_i == spllk_pkg::ADDR_IRQ_STAT) ? {30'h0, irq_stat_q} :
      hit_en ? {30'h0, irq_en_q} : 32'h0000_0000;

   // write effects land on the edge where the master sees ack
   assign pwr_d = wr_now & hit_pwr ?
                  ((pwr_q & ~wmask) | (wb_dat_i & wmask)) & spllk_pkg::PWR_MASK : pwr_q;
   assign div_d = wr_now & hit_div & wb_sel_i[0] ?
                  spllk_pkg::spllk_div_type'(wb_dat_i[7:0]) : div_q;
   assign irq_en_d = wr_now & hit_en & wb_sel_i[0] ? wb_dat_i[1:0] : irq_en_q;

   wire logic pd = pwr_q[spllk_pkg::PWR_PD_BIT];
   wire logic [4:0] p_val = p_value(div_q.psel);
   wire logic [4:0] p_last = p_val - 5'h01;
   // M minus one is the raw field
   wire logic [4:0] m_last = div_q.feedback_div_select;

   wire logic osc_rise = osc_clk_in & ~osc_prev_q;
   wire logic ref_rise = ref_clk_in & ~ref_prev_q;
   wire logic main_rise = main_d & ~main_q;
   wire logic fb_rise = fb_d & ~fb_q;

   // toggle every P oscillator edges gives 2P period, even duty
   assign pcnt_d = pd ? spllk_pkg::PCNT_RESET :
                   !osc_rise ? pcnt_q :
                   (pcnt_q >= p_last) ? spllk_pkg::PCNT_RESET : pcnt_q + 5'h01;
   assign post_d = pd ? 1'b0 : (osc_rise && pcnt_q >= p_last) ? ~post_q : post_q;
   // normal mode output is the post divider
   // bypass sends the oscillator straight out
   assign main_d = pd ? 1'b0 : div_q.bypass ? osc_clk_in : post_d;

   // one feedback edge per M main edges
   wire logic fb_wrap = main_rise && fcnt_q >= m_last;
   assign fcnt_d = pd ? spllk_pkg::FCNT_RESET :
                   !main_rise ? fcnt_q :
                   fb_wrap ? spllk_pkg::FCNT_RESET : fcnt_q + 5'h01;
   assign fb_d = pd ? 1'b0 : fb_wrap ? 1'b1 : main_rise ? 1'b0 : fb_q;

   // phase error is the age of the last feedback edge at the reference edge
   assign since_fb_d = pd ? spllk_pkg::SINCE_FB_MAX :
                       fb_rise ? 8'h00 :
                       (since_fb_q == spllk_pkg::SINCE_FB_MAX) ? since_fb_q :
                       since_fb_q + 8'h01;
   wire logic compare = ref_rise & ~pd;
   wire logic match = since_fb_q <= spllk_pkg::LOCK_CRIT_CYC;

   assign match_cnt_d = pd ? spllk_pkg::LOCK_MATCH_RESET :
                        !compare ? match_cnt_q :
                        !match ? spllk_pkg::LOCK_MATCH_RESET :
                        (match_cnt_q > spllk_pkg::LOCK_MATCH_LAST) ? match_cnt_q :
                        match_cnt_q + 4'h1;
   // lock only from the count, low in power-down
   assign lock_d = pd ? 1'b0 :
                   !compare ? lock_q :
                   !match ? 1'b0 :
                   (match_cnt_q >= spllk_pkg::LOCK_MATCH_LAST) ? 1'b1 : lock_q;

   // set wins over a clear in the same cycle
   wire logic [1:0] irq_set = {lock_q & ~lock_d, lock_d & ~lock_q};
   wire logic [1:0] irq_clr = wr_now & hit_clr & wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0;
   assign irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q <= spllk_pkg::PWR_RESET;
         div_q <= spllk_pkg::spllk_div_type'(spllk_pkg::DIV_RESET);
         irq_en_q <= spllk_pkg::IRQ_RESET;
         irq_stat_q <= spllk_pkg::IRQ_RESET;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else if (ce) begin
         pwr_q <= pwr_d;
         div_q <= div_d;
         irq_en_q <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         ack_q <= req & ~ack_q;
         dat_q <= req & ~ack_q & ~wb_we_i ? rdata : 32'h0000_0000;
         irq_q <= |(irq_stat_d & irq_en_d);
      end
   end

   // dividers and comparison held at their reset values while powered down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_prev_q <= 1'b0;
         ref_prev_q <= 1'b0;
         pcnt_q <= spllk_pkg::PCNT_RESET;
         fcnt_q <= spllk_pkg::FCNT_RESET;
         post_q <= 1'b0;
         main_q <= 1'b0;
         fb_q <= 1'b0;
         since_fb_q <= spllk_pkg::SINCE_FB_MAX;
         match_cnt_q <= spllk_pkg::LOCK_MATCH_RESET;
         lock_q <= 1'b0;
         run_q <= 1'b0;
      end else if (ce) begin
         osc_prev_q <= osc_clk_in;
         ref_prev_q <= ref_clk_in;
         pcnt_q <= pcnt_d;
         fcnt_q <= fcnt_d;
         post_q <= post_d;
         main_q <= main_d;
         fb_q <= fb_d;
         since_fb_q <= since_fb_d;
         match_cnt_q <= match_cnt_d;
         lock_q <= lock_d;
         run_q <= ~pwr_d[spllk_pkg::PWR_PD_BIT];
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign osc_run = run_q;
   assign main_clk_out = main_q;
   assign fb_clk_out = fb_q;
   // lock flag is already a system clock register
   assign lock = lock_q;
   assign irq = irq_q;

   // checks
   property p_pd_lock_low;
      @(posedge clk) disable iff (!rst_b) (ce && pd) |=> !lock_q;
   endproperty
   a_pd_lock_low: assert property (p_pd_lock_low) else $error("lock high in power-down");

   property p_lock_after_nine;
      @(posedge clk) disable iff (!rst_b)
         $rose(lock_q) |-> $past(match_cnt_q) == 4'h8 && match_cnt_q == 4'h9;
   endproperty
   a_lock_after_nine: assert property (p_lock_after_nine) else $error("lock rose early");

   property p_miss_clears;
      @(posedge clk) disable iff (!rst_b)
         (ce && compare && !match) |=> (match_cnt_q == 4'h0 && !lock_q);
   endproperty
   a_miss_clears: assert property (p_miss_clears) else $error("miss kept count or lock");

   property p_pd_div_reset;
      @(posedge clk) disable iff (!rst_b)
         // oscillator enable tracks the bit itself, so it may rise on the release edge
         (ce && pd) |=> (pcnt_q == 5'h00 && fcnt_q == 5'h00 && !main_q && osc_run == !pd);
   endproperty
   a_pd_div_reset: assert property (p_pd_div_reset) else $error("divider active in power-down");

   property p_post_toggle;
      @(posedge clk) disable iff (!rst_b)
         (ce && !pd && osc_rise && pcnt_q == p_last) |=> post_q != $past(post_q);
   endproperty
   a_post_toggle: assert property (p_post_toggle) else $error("post divider missed toggle");

   property p_post_hold;
      @(posedge clk) disable iff (!rst_b)
         (ce && !pd && osc_rise && pcnt_q < p_last) |=> post_q == $past(post_q);
   endproperty
   a_post_hold: assert property (p_post_hold) else $error("post divider toggled early");

   property p_fb_wrap;
      @(posedge clk) disable iff (!rst_b)
         $rose(fb_q) |-> $past(fcnt_q) == $past(div_q.feedback_div_select) && fcnt_q == 5'h00;
   endproperty
   a_fb_wrap: assert property (p_fb_wrap) else $error("feedback edge at wrong count");

   property p_bypass;
      @(posedge clk) disable iff (!rst_b)
         (ce && !pd && div_q.bypass) |=> main_q == $past(osc_clk_in);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass output wrong");

   property p_match_count;
      @(posedge clk) disable iff (!rst_b)
         (ce && compare && match && match_cnt_q < 4'h9) |=>
            match_cnt_q == $past(match_cnt_q) + 4'h1;
   endproperty
   a_match_count: assert property (p_match_count) else $error("match not counted");

   property p_main_post;
      @(posedge clk) disable iff (!rst_b)
         (ce && !pd && !div_q.bypass) |=> main_q == post_q;
   endproperty
   a_main_post: assert property (p_main_post) else $error("output not from post divider");

   property p_psel_two;
      @(posedge clk) disable iff (!rst_b)
         div_q.psel == 2'b01 |-> p_val == 5'h02;
   endproperty
   a_psel_two: assert property (p_psel_two) else $error("code 01 not P of two");

   property p_psel_four;
      @(posedge clk) disable iff (!rst_b)
         div_q.psel == 2'b10 |-> p_val == 5'h04;
   endproperty
   a_psel_four: assert property (p_psel_four) else $error("code 10 not P of four");

   property p_pd_compare_stop;
      @(posedge clk) disable iff (!rst_b)
         (ce && pd) |=> (since_fb_q == spllk_pkg::SINCE_FB_MAX && match_cnt_q == 4'h0);
   endproperty
   a_pd_compare_stop: assert property (p_pd_compare_stop) else $error("compare ran");

   property p_lock_read;
      @(posedge clk) disable iff (!rst_b)
         (ce && req && !ack_q && !wb_we_i && wb_adr_i == spllk_pkg::ADDR_STAT) |=>
            wb_dat_o[spllk_pkg::STAT_LOCK_BIT] == $past(lock_q);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("status read lost lock");

   property p_ack_pulse;
      @(posedge clk) disable iff (!rst_b)
         (ce && wb_ack_o) |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

   property p_loss_sets;
      @(posedge clk) disable iff (!rst_b)
         (ce && lock_q && !lock_d) |=> irq_stat_q[spllk_pkg::IRQ_LOCK_LOSS_BIT];
   endproperty
   a_loss_sets: assert property (p_loss_sets) else $error("lock loss not flagged");

   property p_irq_level;
      @(posedge clk) disable iff (!rst_b)
         irq == |(irq_stat_q & irq_en_q);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

   c_lock_gain: cover property (@(posedge clk) disable iff (!rst_b) $rose(lock_q));
   c_lock_loss: cover property (@(posedge clk) disable iff (!rst_b) $fell(lock_q) && !pd);
   c_bypass_run: cover property (@(posedge clk) disable iff (!rst_b) !pd && div_q.bypass);
   c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq_q));
   c_ce_freeze: cover property (@(posedge clk) disable iff (!rst_b) !ce && lock_q);
endmodule

// *** test/spllk_ref_model.sv ***
// reference clock and oscillator model on the far side of the loop block
`timescale 1ns/1ps
module spllk_ref_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic osc_run,
   input wire logic fb_clk,
   input wire logic misalign,
   output logic ref_clk,
   output logic osc_clk
);
   logic [5:0] fb_dly_q;
   logic [1:0] osc_cnt_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fb_dly_q <= 6'h00;
         osc_cnt_q <= 2'h0;
      end else begin
         fb_dly_q <= {fb_dly_q[4:0], fb_clk};
         osc_cnt_q <= osc_run ? osc_cnt_q + 2'h1 : 2'h0;
      end
   end
   // fixed scaled rate
   // oscillator is a quarter of clk so every level spans two samples
   assign osc_clk = osc_run & osc_cnt_q[1];
   // source tracks feedback
   // misalign delays the edge well past the criterion to force misses
   assign ref_clk = misalign ? fb_dly_q[5] : fb_clk;
endmodule

// *** test/tb_system_pll_lock_and_dividers.sv ***
// self-checking bench for the loop divider and lock detector block
`timescale 1ns/1ps
module tb_system_pll_lock_and_dividers;
   logic clk, rst_b, cyc, stb, we, misalign, ce;
   logic [7:0] adr;
   logic [31:0] dat, wb_dat_o, rd, n;
   logic wb_ack_o, ref_clk, osc_clk, osc_run, main_clk_out, fb_clk_out, lock, irq;
   int fails = 0;
   int tests_run = 0;
   spllk_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ref_clk_in(ref_clk), .osc_clk_in(osc_clk), .osc_run(osc_run),
      .main_clk_out(main_clk_out), .fb_clk_out(fb_clk_out), .lock(lock), .irq(irq));
   spllk_ref_model far (.clk(clk), .rst_b(rst_b), .osc_run(osc_run), .fb_clk(fb_clk_out),
      .misalign(misalign), .ref_clk(ref_clk), .osc_clk(osc_clk));
   always #5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      rd = wb_dat_o;
      if (i >= 50) chk(32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // n gets the clk count between two rises of main or feedback
   task automatic per(input logic fb);
      logic pr, cur;
      int i, k;
      pr = 1'b1;
      k = 0;
      n = 0;
      for (i = 0; i < 600 && k < 2; i++) begin
         @(posedge clk);
         #1;
         cur = fb ? fb_clk_out : main_clk_out;
         if (cur === 1'b1 && pr === 1'b0) k++;
         if (k == 1) n++;
         pr = cur;
      end
   endtask
   // n gets the reference rises seen before lock reaches lvl
   task automatic wait_lock(input logic lvl);
      logic pr;
      int i;
      n = 0;
      pr = ref_clk;
      for (i = 0; i < 4000 && lock !== lvl; i++) begin
         @(posedge clk);
         #1;
         if (ref_clk === 1'b1 && pr === 1'b0) n++;
         pr = ref_clk;
      end
      chk({31'h0, lock}, {31'h0, lvl});
   endtask
   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatched %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #400000;
      chk(32'h0, 32'h1);
      complete_run();
   end
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      misalign = 1'b0;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(8'h00, 32'h0000_6DF0);
      rdchk(8'h04, 32'h0);
      rdchk(8'h08, 32'h2);
      chk({31'h0, osc_run}, 32'h0);
      wb(1'b1, 8'h00, 32'hFFFF_FFFF);
      rdchk(8'h00, 32'h0000_7FFF);
      wb(1'b1, 8'h08, 32'h1);
      rdchk(8'h08, 32'h2);
      wb(1'b1, 8'h20, 32'h1);
      rdchk(8'h20, 32'h0);
      tdone("registers");
      wb(1'b1, 8'h04, 32'h1);
      wb(1'b1, 8'h14, 32'h2);
      wb(1'b1, 8'h00, 32'h0000_6D70);
      wait_lock(1'b1);
      chk(n, 32'h9);
      rdchk(8'h08, 32'h1);
      rdchk(8'h0C, 32'h1);
      chk({31'h0, irq}, 32'h0);
      per(1'b0);
      chk(n, 32'h8);
      per(1'b1);
      chk(n, 32'h10);
      // clock enable low must freeze dividers and lock
      @(posedge clk);
      ce <= 1'b0;
      per(1'b0);
      chk(n, 32'h0);
      chk({31'h0, lock}, 32'h1);
      @(posedge clk);
      ce <= 1'b1;
      tdone("lock");
      misalign <= 1'b1;
      wait_lock(1'b0);
      rdchk(8'h0C, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h10, 32'h3);
      rdchk(8'h0C, 32'h0);
      chk({31'h0, irq}, 32'h0);
      misalign <= 1'b0;
      wait_lock(1'b1);
      wb(1'b1, 8'h00, 32'h0000_6DF0);
      repeat (3) @(posedge clk);
      #1;
      chk({29'h0, osc_run, main_clk_out, lock}, 32'h0);
      rdchk(8'h08, 32'h2);
      tdone("loss");
      for (int p = 1; p < 4; p++) begin
         wb(1'b1, 8'h04, 32'(p << 5) | 32'h2);
         wb(1'b1, 8'h00, 32'h0000_6D70);
         wait_lock(1'b1);
         per(1'b0);
         chk(n, 32'(8 << p));
         per(1'b1);
         chk(n, 32'(24 << p));
         wb(1'b1, 8'h00, 32'h0000_6DF0);
      end
      wb(1'b1, 8'h04, 32'h80);
      wb(1'b1, 8'h00, 32'h0000_6D70);
      per(1'b0);
      chk(n, 32'h4);
      tdone("dividers");
      complete_run();
   end
endmodule
